// *** cap_display_request_n_pkg.sv ***
// Constants and types for the capacity register bank and LED display
package cap_display_request_n_pkg;
	localparam logic [7:0] ADDR_NOMINAL = 8'h03;
	localparam logic [7:0] ADDR_LEARNED = 8'h05;
	localparam logic [7:0] ADDR_TEMP_COMP = 8'h0D;
	localparam logic [7:0] ADDR_RATE_COMP = 8'h0E;
	localparam logic [7:0] ADDR_ENERGY_HI = 8'h0F;
	localparam logic [7:0] ADDR_ENERGY_LO = 8'h10;
	localparam logic [7:0] ADDR_REL_CHARGE = 8'h11;
	localparam logic [7:0] ADDR_AVG_HI = 8'h12;
	localparam logic [7:0] ADDR_AVG_LO = 8'h13;
	localparam logic [7:0] ADDR_DCOUNT = 8'h18;
	localparam logic [7:0] ADDR_PULSE_ACT = 8'h38;
	localparam logic [7:0] ADDR_PROG_PIN = 8'h3F;
	localparam int PULSE_CHG_BIT = 0;
	localparam int PULSE_DCHG_BIT = 3;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] REL_FULL = 8'h64;
	localparam logic [7:0] SEG_STEP = 8'h14;
	localparam logic [15:0] DCOUNT_MAX = 16'hFFFF;
	localparam logic [4:0] BANK_A_MASK = 5'h15;
	localparam logic [4:0] BANK_B_MASK = 5'h0A;
	localparam int RATE_COMP_SHIFT = 3;
	localparam int TEMP_COMP_SHIFT = 2;
	localparam int VSB_FULL_SCALE_MV = 1200;
	localparam int VSB_STEPS = 256;
	localparam int FINAL_EMPTY_FLAG_DELTA_MV = 25;
	localparam int FINAL_EMPTY_FLAG_DELTA_LSB = FINAL_EMPTY_FLAG_DELTA_MV * VSB_STEPS / VSB_FULL_SCALE_MV;
	localparam int CLK_HZ = 10000000;
	localparam int AVG_PERIOD_MS = 22500;
	localparam int AVG_CYCLES = AVG_PERIOD_MS * (CLK_HZ / 1000);
	localparam int DISPLAY_REQUEST_N_HOLD_MS = 4000;
	localparam int DISPLAY_REQUEST_N_CYCLES = DISPLAY_REQUEST_N_HOLD_MS * (CLK_HZ / 1000);
	localparam int MUX_HZ = 100;
	localparam int MUX_CYCLES = CLK_HZ / MUX_HZ;
	localparam int MUX_ON_PCT = 30;
	localparam int BLINK_HZ = 4;
	localparam int BLINK_CYCLES = CLK_HZ / BLINK_HZ;
	typedef enum logic {RST_IDLE, RST_ARMED} reset_req_type;
endpackage : cap_display_request_n_pkg

// *** cap_display_request_n.sv ***
// Capacity registers, software reset, pulse activity and LED display
//
// What this block does
// RULE1 - Discharge: compensated capacity only ever drops
// RULE2 - Charge: compensated capacity follows nominal capacity
// RULE3 - Above 2C, compensated below nominal
// RULE4 - Cold derate gives temp-compensated capacity, display
// RULE5 - Energy word from voltage times capacity
// RULE6 - Relative charge is capacity over full, 0-64h
// RULE7 - Average current pair refreshed each 22.5 s
// RULE8 - Sign bit marks average discharge current
// RULE9 - Discharge count clears, saturates, stops when empty
// RULE10 - Zero program count then zero full: reset
// RULE11 - Reset reloads full count, clears capacity registers
// RULE12 - Activity bits flag counted charge, discharge pulses
// RULE13 - One segment per 20 percent of full
// RULE14 - Temperature derate leaves nominal capacity alone
// RULE15 - Request high: dark; floating: lit while charging
// RULE16 - Request low lights segments four seconds
// RULE17 - Banks 1-3-5 and 2-4 alternate, 100 Hz
// RULE18 - First empty: segment 1 blinks at 4 Hz
// RULE19 - Final empty: display fully dark
// RULE20 - Nominal counts up on charge, down on discharge
// RULE21 - Final empty sits 25 mV below first empty
// RULE22 - Registers reachable bytewise at their addresses; discharge count shows only its high byte, at 18h
`timescale 1ns/100ps
`default_nettype none
module cap_display_request_n
	import cap_display_request_n_pkg::*;
#(
	parameter int AVG_CYCLES_P = AVG_CYCLES,
	parameter int DISPLAY_REQUEST_N_CYCLES_P = DISPLAY_REQUEST_N_CYCLES,
	parameter int MUX_CYCLES_P = MUX_CYCLES,
	parameter int BLINK_CYCLES_P = BLINK_CYCLES
) (
	// Clock, reset, enable
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	// Register port from the serial engine
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WRITE,
	input wire logic REG_READ,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	// Measurement front end
	input wire logic CHG_PULSE,
	input wire logic DCHG_PULSE,
	input wire logic SELF_DCHG_PULSE,
	input wire logic CHARGING,
	input wire logic RATE_ABOVE_2C,
	input wire logic TEMP_BELOW_10C,
	input wire logic VALID_DISCHARGE_START,
	input wire logic VALID_CHARGE_THRESHOLD,
	input wire logic [7:0] BATT_VOLTAGE,
	input wire logic [7:0] VOLT_THRESHOLD,
	input wire logic signed [15:0] SENSE_VALUE,
	input wire logic [7:0] PROGRAMMED_FULL_COUNT,
	// Display
	input wire logic DISPLAY_REQUEST_N,
	input wire logic DISPLAY_FLOATING,
	output logic [4:0] LED_SEGMENT_OUT,
	output logic LED_COMMON,
	// Reset notice for flags held elsewhere
	output logic SOFT_RESET_PULSE
);
	localparam int AW = $clog2(AVG_CYCLES_P + 1);
	localparam int DW = $clog2(DISPLAY_REQUEST_N_CYCLES_P + 1);
	localparam int MW = $clog2(MUX_CYCLES_P + 1);
	localparam int BW = $clog2(BLINK_CYCLES_P + 1);
	localparam int MUX_ON = MUX_CYCLES_P * MUX_ON_PCT / 100;
	localparam int MUX_HALF = MUX_CYCLES_P / 2;

	function automatic logic [7:0] sub_frac(input logic [7:0] x, input int sh);
		return x - (x >> sh);
	endfunction : sub_frac

	function automatic logic [7:0] rel_pct(input logic [7:0] cap, input logic [7:0] full);
		logic [15:0] q;
		q = 16'h0000;
		if (full != ZERO_BYTE)
			q = (16'(cap) * 16'(REL_FULL)) / 16'(full);
		if (q > 16'(REL_FULL))
			q = 16'(REL_FULL);
		return q[7:0];
	endfunction : rel_pct

	function automatic logic [4:0] seg_pattern(input logic [7:0] pct);
		logic [4:0] lit;
		lit = 5'h00;
		for (int k = 0; k < 5; k++)
			lit[k] = 16'(pct) > 16'(SEG_STEP) * 16'(k);
		return lit;
	endfunction : seg_pattern

	logic [7:0] nominal_ff, learned_ff, prog_pin_ff;
	logic [7:0] rate_comp_ff, temp_comp_ff, rel_pct_ff;
	logic [15:0] energy_ff, avg_ff, dcount_ff;
	logic [7:0] pulse_act_ff;
	logic first_empty_ff, final_empty_ff;
	logic soft_rst_ff;
	reset_req_type req_state_ff;
	logic [AW-1:0] avg_cnt_ff;
	logic signed [47:0] acc_ff;
	logic [DW-1:0] display_request_n_timer_ff;
	logic [MW-1:0] mux_cnt_ff;
	logic [BW-1:0] blink_cnt_ff;
	logic [4:0] led_ff;
	logic led_com_ff;
	logic [7:0] rdata_ff;

	logic wr_lmd, wr_prog, wipe, fire, rd_pulse;
	logic [7:0] rate_cand, rd_mux;
	logic signed [47:0] acc_sum, avg_q;
	logic display_request_n_on, bank_a, bank_b, blink_on;
	logic [4:0] pattern;

	assign wr_lmd = REG_WRITE && REG_ADDR == ADDR_LEARNED;
	assign wr_prog = REG_WRITE && REG_ADDR == ADDR_PROG_PIN;
	assign fire = wr_lmd && REG_WDATA == ZERO_BYTE && req_state_ff == RST_ARMED;
	assign wipe = soft_rst_ff;
	assign rd_pulse = REG_READ && REG_ADDR == ADDR_PULSE_ACT;

	// Software reset request sequence
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			req_state_ff <= RST_IDLE;
		end else if (CLK_EN) begin
			unique case (req_state_ff)
				RST_IDLE: begin
					if (wr_prog && REG_WDATA == ZERO_BYTE) // RULE10
						req_state_ff <= RST_ARMED;
				end
				RST_ARMED: begin
					if (wr_lmd || wr_prog)
						req_state_ff <= RST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N)
			soft_rst_ff <= 1'b0;
		else if (CLK_EN)
			soft_rst_ff <= fire; // RULE10
	end

	// Program pin count: reloaded from the pins, host may write any value to it
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N || (CLK_EN && wipe))
			prog_pin_ff <= PROGRAMMED_FULL_COUNT;
		else if (CLK_EN && wr_prog)
			prog_pin_ff <= REG_WDATA;
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N || (CLK_EN && wipe))
			learned_ff <= PROGRAMMED_FULL_COUNT; // RULE11
		else if (CLK_EN && wr_lmd)
			learned_ff <= REG_WDATA;
	end

	// Temperature never enters this count
	always_ff @(posedge CORE_CLK) begin // RULE14
		if (!RESET_N || (CLK_EN && wipe)) begin
			nominal_ff <= ZERO_BYTE; // RULE11
		end else if (CLK_EN) begin
			if (CHG_PULSE && nominal_ff < learned_ff)
				nominal_ff <= nominal_ff + 8'h01; // RULE20
			else if ((DCHG_PULSE || SELF_DCHG_PULSE) && nominal_ff != ZERO_BYTE)
				nominal_ff <= nominal_ff - 8'h01; // RULE20
		end
	end

	assign rate_cand = RATE_ABOVE_2C ? sub_frac(nominal_ff, RATE_COMP_SHIFT) : nominal_ff; // RULE3

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N || (CLK_EN && wipe)) begin
			rate_comp_ff <= ZERO_BYTE;
		end else if (CLK_EN) begin
			if (CHARGING)
				rate_comp_ff <= nominal_ff; // RULE2
			else if (rate_cand < rate_comp_ff)
				rate_comp_ff <= rate_cand; // RULE1
		end
	end

	// Derived values lag their sources by one cycle each
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N || (CLK_EN && wipe)) begin
			temp_comp_ff <= ZERO_BYTE;
			energy_ff <= 16'h0000;
			rel_pct_ff <= ZERO_BYTE;
		end else if (CLK_EN) begin
			temp_comp_ff <= TEMP_BELOW_10C ?
				sub_frac(rate_comp_ff, TEMP_COMP_SHIFT) : rate_comp_ff; // RULE4
			energy_ff <= 16'(BATT_VOLTAGE) * 16'(temp_comp_ff); // RULE5
			rel_pct_ff <= rel_pct(temp_comp_ff, learned_ff); // RULE6
		end
	end

	// Final empty compare adds the offset to avoid wrapping below zero
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			first_empty_ff <= 1'b0;
			final_empty_ff <= 1'b0;
		end else if (CLK_EN) begin
			first_empty_ff <= BATT_VOLTAGE < VOLT_THRESHOLD;
			final_empty_ff <= 9'(BATT_VOLTAGE) + 9'(FINAL_EMPTY_FLAG_DELTA_LSB) < 9'(VOLT_THRESHOLD); // RULE21
		end
	end

	assign acc_sum = acc_ff + 48'(SENSE_VALUE);
	assign avg_q = acc_sum / 48'(AVG_CYCLES_P);

	// One sample per enabled cycle, so the divisor is the window length
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			acc_ff <= 48'h000000000000;
			avg_cnt_ff <= '0;
			avg_ff <= 16'h0000;
		end else if (CLK_EN) begin
			if (avg_cnt_ff == AW'(AVG_CYCLES_P - 1)) begin
				avg_cnt_ff <= '0;
				acc_ff <= 48'h000000000000;
				avg_ff <= avg_q[15:0]; // RULE7 RULE8
			end else begin
				avg_cnt_ff <= avg_cnt_ff + AW'(1);
				acc_ff <= acc_sum;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			dcount_ff <= 16'h0000;
		end else if (CLK_EN) begin
			if (VALID_DISCHARGE_START)
				dcount_ff <= 16'h0000; // RULE9
			else if (DCHG_PULSE && !first_empty_ff && dcount_ff != DCOUNT_MAX)
				dcount_ff <= dcount_ff + 16'h0001; // RULE9
		end
	end

	// Cleared by reading; a pulse in the read cycle still sets
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			pulse_act_ff <= ZERO_BYTE;
		end else if (CLK_EN) begin
			pulse_act_ff <= rd_pulse ? ZERO_BYTE : pulse_act_ff;
			if (CHG_PULSE)
				pulse_act_ff[PULSE_CHG_BIT] <= 1'b1; // RULE12
			if (DCHG_PULSE)
				pulse_act_ff[PULSE_DCHG_BIT] <= 1'b1; // RULE12
		end
	end

	always_comb begin
		unique case (REG_ADDR) // RULE22
			ADDR_NOMINAL: rd_mux = nominal_ff;
			ADDR_LEARNED: rd_mux = learned_ff;
			ADDR_TEMP_COMP: rd_mux = temp_comp_ff;
			ADDR_RATE_COMP: rd_mux = rate_comp_ff;
			ADDR_ENERGY_HI: rd_mux = energy_ff[15:8];
			ADDR_ENERGY_LO: rd_mux = energy_ff[7:0];
			ADDR_REL_CHARGE: rd_mux = rel_pct_ff;
			ADDR_AVG_HI: rd_mux = avg_ff[15:8];
			ADDR_AVG_LO: rd_mux = avg_ff[7:0];
			ADDR_DCOUNT: rd_mux = dcount_ff[15:8];
			ADDR_PULSE_ACT: rd_mux = pulse_act_ff;
			ADDR_PROG_PIN: rd_mux = prog_pin_ff;
			default: rd_mux = ZERO_BYTE;
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N)
			rdata_ff <= ZERO_BYTE;
		else if (CLK_EN && REG_READ)
			rdata_ff <= rd_mux; // RULE22
	end

	// Display hold timer, retriggered while the request is held low
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			display_request_n_timer_ff <= '0;
		end else if (CLK_EN) begin
			if (!DISPLAY_FLOATING && !DISPLAY_REQUEST_N)
				display_request_n_timer_ff <= DW'(DISPLAY_REQUEST_N_CYCLES_P); // RULE16
			else if (display_request_n_timer_ff != '0)
				display_request_n_timer_ff <= display_request_n_timer_ff - DW'(1);
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			mux_cnt_ff <= '0;
			blink_cnt_ff <= '0;
		end else if (CLK_EN) begin
			mux_cnt_ff <= (mux_cnt_ff == MW'(MUX_CYCLES_P - 1)) ? '0 : mux_cnt_ff + MW'(1);
			blink_cnt_ff <= (blink_cnt_ff == BW'(BLINK_CYCLES_P - 1)) ?
				'0 : blink_cnt_ff + BW'(1);
		end
	end

	assign bank_a = mux_cnt_ff < MW'(MUX_ON); // RULE17
	assign bank_b = mux_cnt_ff >= MW'(MUX_HALF) && mux_cnt_ff < MW'(MUX_HALF + MUX_ON);
	assign blink_on = blink_cnt_ff < BW'(BLINK_CYCLES_P / 2);
	assign display_request_n_on = !final_empty_ff && // RULE19
		(display_request_n_timer_ff != '0 || (DISPLAY_FLOATING && VALID_CHARGE_THRESHOLD)); // RULE15
	assign pattern = first_empty_ff ? {4'h0, blink_on} : seg_pattern(rel_pct_ff); // RULE18 RULE13

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			led_ff <= 5'h00;
			led_com_ff <= 1'b0;
		end else if (CLK_EN) begin
			led_ff <= display_request_n_on ? pattern & ((bank_a ? BANK_A_MASK : 5'h00) |
				(bank_b ? BANK_B_MASK : 5'h00)) : 5'h00; // RULE17
			led_com_ff <= display_request_n_on && (bank_a || bank_b);
		end
	end

	assign REG_RDATA = rdata_ff;
	assign LED_SEGMENT_OUT = led_ff;
	assign LED_COMMON = led_com_ff;
	assign SOFT_RESET_PULSE = soft_rst_ff;

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESET_N);

	AST_RATE_NO_RISE: assert property ( // RULE1
		CLK_EN && !CHARGING && !wipe |=> rate_comp_ff <= $past(rate_comp_ff))
		else $error("compensated capacity rose during discharge");
	AST_RATE_TRACKS: assert property ( // RULE2
		CLK_EN && CHARGING && !wipe |=> rate_comp_ff == $past(nominal_ff))
		else $error("compensated capacity not following nominal");
	AST_TEMP_COLD: assert property ( // RULE4
		CLK_EN && TEMP_BELOW_10C && !wipe && rate_comp_ff >= 8'h04
		|=> temp_comp_ff < $past(rate_comp_ff))
		else $error("cold derate missing");
	AST_REL_RANGE: assert property ( // RULE6
		rel_pct_ff <= REL_FULL)
		else $error("relative charge above full");
	AST_DCOUNT_HOLD: assert property ( // RULE9
		CLK_EN && !VALID_DISCHARGE_START && (first_empty_ff || dcount_ff == DCOUNT_MAX)
		|=> $stable(dcount_ff))
		else $error("discharge count moved while blocked");
	AST_RESET_FIRE: assert property ( // RULE10
		CLK_EN && fire |=> soft_rst_ff)
		else $error("reset request not honoured");
	AST_RESET_CLEARS: assert property ( // RULE11
		CLK_EN && soft_rst_ff |=> nominal_ff == ZERO_BYTE && rel_pct_ff == ZERO_BYTE
		&& learned_ff == $past(PROGRAMMED_FULL_COUNT))
		else $error("software reset left state");
	AST_PULSE_SET: assert property ( // RULE12
		CLK_EN && CHG_PULSE |=> pulse_act_ff[PULSE_CHG_BIT])
		else $error("charge activity bit not set");
	AST_FINAL_DARK: assert property ( // RULE19
		CLK_EN && final_empty_ff |=> led_ff == 5'h00)
		else $error("display lit at final empty");
	AST_ONE_BANK: assert property ( // RULE17
		!(|(led_ff & BANK_A_MASK) && |(led_ff & BANK_B_MASK)))
		else $error("both banks lit together");

	COV_SOFT_RESET: cover property (soft_rst_ff && CLK_EN);
	COV_BLINK: cover property (first_empty_ff && led_ff[0]);
	COV_HOLD: cover property (display_request_n_timer_ff == DW'(1) && CLK_EN);
endmodule : cap_display_request_n
`default_nettype wire

// *** host_port_model.sv ***
// Host side of the register port: byte reads, writes and the reset request
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] reg_addr,
	output logic reg_write,
	output logic reg_read,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_wdata = 8'h00;
	end

	// Released lines carry the inverse so a stale value never passes
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		reg_addr <= addr;
		reg_wdata <= data;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		reg_addr <= ~addr;
		reg_wdata <= ~data;
	endtask : write_reg

	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk);
		reg_addr <= addr;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		reg_addr <= ~addr;
		// Read data has stood since the taking edge, so the edge itself is safe
		@(posedge clk);
		data = reg_rdata;
	endtask : read_reg

	task automatic reset_request();
		write_reg(8'h3F, 8'h00);
		write_reg(8'h05, 8'h00);
	endtask : reset_request
endmodule : host_port_model
`default_nettype wire

// *** cap_display_request_n_tb.sv ***
// Self-checking bench for the capacity registers and LED display
`timescale 1ns/100ps
`default_nettype none
module cap_display_request_n_tb;
	import cap_display_request_n_pkg::*;
	localparam int DISPLAY_REQUEST_N_HOLD = 40;
	typedef struct {
		int n;
		logic cold;
		logic [7:0] volt, nom, rate, temp, rel;
		logic [15:0] energy;
	} row_type;
	row_type rows [3] = '{
		'{40, 1'b0, 8'h10, 8'h28, 8'h28, 8'h28, 8'h28, 16'h0280},
		'{40, 1'b1, 8'h20, 8'h50, 8'h50, 8'h3C, 8'h3C, 16'h0780},
		'{30, 1'b0, 8'hFF, 8'h64, 8'h64, 8'h64, 8'h64, 16'h639C}};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [3:0] pulse_vec = 4'h0;
	logic charging = 1'b1;
	logic rate_2c = 1'b0;
	logic cold = 1'b0;
	logic chg_valid = 1'b0;
	logic [7:0] batt_volt = 8'h10;
	logic [7:0] volt_thr = 8'h00;
	logic display_request_n_req_n = 1'b1;
	logic display_request_n_float = 1'b0;
	logic [7:0] addr, wdata, rdata, hi, lo;
	logic wr, rd, common, soft_pulse;
	logic [4:0] led, seen;
	int mismatches = 0;
	int checked = 0;
	int pulses = 0;
	int a_cnt;

	always #50 clk = ~clk;
	always @(posedge clk) if (soft_pulse === 1'b1) pulses++;

	host_port_model host_port_model_inst (.clk(clk), .reg_addr(addr), .reg_write(wr),
		.reg_read(rd), .reg_wdata(wdata), .reg_rdata(rdata));

	cap_display_request_n #(.AVG_CYCLES_P(16), .DISPLAY_REQUEST_N_CYCLES_P(DISPLAY_REQUEST_N_HOLD), .MUX_CYCLES_P(20),
		.BLINK_CYCLES_P(16)) cap_display_request_n_inst (
		.CORE_CLK(clk), .RESET_N(rst_n), .CLK_EN(clk_en),
		.REG_ADDR(addr), .REG_WRITE(wr), .REG_READ(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
		.CHG_PULSE(pulse_vec[0]), .DCHG_PULSE(pulse_vec[1]), .SELF_DCHG_PULSE(pulse_vec[2]),
		.CHARGING(charging), .RATE_ABOVE_2C(rate_2c), .TEMP_BELOW_10C(cold),
		.VALID_DISCHARGE_START(pulse_vec[3]), .VALID_CHARGE_THRESHOLD(chg_valid),
		.BATT_VOLTAGE(batt_volt), .VOLT_THRESHOLD(volt_thr), .SENSE_VALUE(16'hFFFB),
		.PROGRAMMED_FULL_COUNT(8'h64), .DISPLAY_REQUEST_N(display_request_n_req_n),
		.DISPLAY_FLOATING(display_request_n_float), .LED_SEGMENT_OUT(led), .LED_COMMON(common),
		.SOFT_RESET_PULSE(soft_pulse));

	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check_byte

	task automatic check_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host_port_model_inst.read_reg(a, d);
		check_byte(what, exp, d);
	endtask : check_reg

	task automatic pulse_input(input logic [3:0] which, input int n);
		repeat (n) begin
			@(posedge clk);
			pulse_vec <= which;
			@(posedge clk);
			pulse_vec <= 4'h0;
		end
		repeat (4) @(posedge clk);
	endtask : pulse_input

	// Collects lit segments; a bank-A count over whole mux periods gives the duty
	task automatic watch_leds(input int cycles, output logic [4:0] lit, output int a_on);
		lit = 5'h00;
		a_on = 0;
		repeat (cycles) begin
			@(posedge clk);
			#1;
			lit = lit | led;
			if ((led & BANK_A_MASK) != 5'h00) a_on++;
			check_byte("bank overlap", 8'h00, {7'h0, |(led & BANK_A_MASK) & |(led & BANK_B_MASK)});
			if (led != 5'h00) check_byte("common", 8'h01, {7'h0, common});
		end
		// Back on the edge so the caller drives inputs there
		@(posedge clk);
	endtask : watch_leds

	task automatic complete_run();
		if (mismatches == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run

	// Whole run is under a thousand cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		complete_run();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		check_reg("energy hi", 8'h0F, 8'h00);
		check_reg("learned", 8'h05, 8'h64);
		foreach (rows[i]) begin
			cold <= rows[i].cold;
			batt_volt <= rows[i].volt;
			pulse_input(4'h1, rows[i].n);
			check_reg("nominal", 8'h03, rows[i].nom);
			check_reg("rate comp", 8'h0E, rows[i].rate);
			check_reg("temp comp", 8'h0D, rows[i].temp);
			check_reg("rel charge", 8'h11, rows[i].rel);
			check_reg("energy hi", 8'h0F, rows[i].energy[15:8]);
			check_reg("energy lo", 8'h10, rows[i].energy[7:0]);
		end
		check_reg("activity", 8'h38, 8'h01);
		check_reg("activity cleared", 8'h38, 8'h00);
		charging <= 1'b0;
		rate_2c <= 1'b1;
		pulse_input(4'h0, 1);
		check_reg("rate comp 2C", 8'h0E, 8'h58);
		pulse_input(4'h2, 10);
		pulse_input(4'h4, 1);
		check_reg("nominal", 8'h03, 8'h59);
		check_reg("rate comp", 8'h0E, 8'h4E);
		check_reg("activity", 8'h38, 8'h08);
		rate_2c <= 1'b0;
		pulse_input(4'h0, 1);
		check_reg("rate comp held", 8'h0E, 8'h4E);
		host_port_model_inst.write_reg(8'h0E, 8'h55);
		check_reg("read-only", 8'h0E, 8'h4E);
		check_reg("unmapped", 8'h20, 8'h00);
		check_reg("rel charge", 8'h11, 8'h4E);
		host_port_model_inst.read_reg(8'h12, hi);
		host_port_model_inst.read_reg(8'h13, lo);
		check_byte("avg high", 8'hFF, hi);
		check_byte("avg low", 8'hFB, lo);
		check_byte("discharge size", 8'h05, 8'(-{hi, lo}));
		pulse_input(4'h8, 1);
		check_reg("discharge count", 8'h18, 8'h00);
		display_request_n_req_n <= 1'b0;
		// Timer load and LED register lag, so the window holds only lit cycles
		repeat (2) @(posedge clk);
		watch_leds(40, seen, a_cnt);
		check_byte("segments", 8'h0F, {3'h0, seen});
		check_byte("bank A share", 8'h0C, a_cnt[7:0]);
		display_request_n_req_n <= 1'b1;
		watch_leds(20, seen, a_cnt);
		check_byte("hold lit", 8'h0F, {3'h0, seen});
		repeat (DISPLAY_REQUEST_N_HOLD) @(posedge clk);
		watch_leds(40, seen, a_cnt);
		check_byte("request high", 8'h00, {3'h0, seen});
		display_request_n_float <= 1'b1;
		chg_valid <= 1'b1;
		watch_leds(40, seen, a_cnt);
		check_byte("floating lit", 8'h0F, {3'h0, seen});
		chg_valid <= 1'b0;
		repeat (4) @(posedge clk);
		watch_leds(40, seen, a_cnt);
		check_byte("floating dark", 8'h00, {3'h0, seen});
		display_request_n_float <= 1'b0;
		display_request_n_req_n <= 1'b0;
		batt_volt <= 8'h10;
		volt_thr <= 8'h12;
		repeat (4) @(posedge clk);
		watch_leds(80, seen, a_cnt);
		check_byte("first empty", 8'h01, {3'h0, seen});
		volt_thr <= 8'h20;
		repeat (4) @(posedge clk);
		watch_leds(40, seen, a_cnt);
		check_byte("final empty", 8'h00, {3'h0, seen});
		display_request_n_req_n <= 1'b1;
		volt_thr <= 8'h00;
		host_port_model_inst.write_reg(8'h3F, 8'h05);
		host_port_model_inst.write_reg(8'h05, 8'h00);
		repeat (4) @(posedge clk);
		check_byte("refused reset", 8'h00, pulses[7:0]);
		host_port_model_inst.reset_request();
		repeat (4) @(posedge clk);
		check_byte("reset pulses", 8'h01, pulses[7:0]);
		check_reg("nominal", 8'h03, 8'h00);
		check_reg("rate comp", 8'h0E, 8'h00);
		check_reg("energy hi", 8'h0F, 8'h00);
		check_reg("energy lo", 8'h10, 8'h00);
		check_reg("rel charge", 8'h11, 8'h00);
		check_reg("learned", 8'h05, 8'h64);
		// Pulses while the enable is low must leave the count alone
		clk_en <= 1'b0;
		pulse_input(4'h1, 3);
		clk_en <= 1'b1;
		check_reg("frozen nominal", 8'h03, 8'h00);
		pulse_input(4'h1, 1);
		check_reg("nominal", 8'h03, 8'h01);
		host_port_model_inst.write_reg(8'h05, 8'h33);
		check_reg("learned write", 8'h05, 8'h33);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		check_reg("learned", 8'h05, 8'h64);
		complete_run();
	end
endmodule : cap_display_request_n_tb
`default_nettype wire
